/* File: rtl/i2h_consts.svh */
`ifndef I2H_CONSTS_SVH
`define I2H_CONSTS_SVH
// --------------------------------------------------------------
// timing base
// --------------------------------------------------------------
`define I2H_CLK_MHZ      100
// wait after supply is stable, in microseconds
`define I2H_PUP_US       100
`define I2H_PUP_CYC      (`I2H_PUP_US * `I2H_CLK_MHZ)
// one quarter of an scl period, in nanoseconds (100 kHz bus)
`define I2H_QTR_NS       2500
`define I2H_QTR_CYC      ((`I2H_QTR_NS * `I2H_CLK_MHZ) / 1000)
// --------------------------------------------------------------
// bit positions within a byte slot, and the recovery clock limit
// --------------------------------------------------------------
`define I2H_BIT_ACK      4'h8
`define I2H_BIT_END      4'h9
`define I2H_RECOV_MAX    4'h9
// quarter phases of one scl cycle
`define I2H_PH_LOW       2'h0
`define I2H_PH_RISE      2'h1
`define I2H_PH_HIGH      2'h2
`define I2H_PH_FALL      2'h3
`endif

/* File: rtl/i2h_host.sv */
`include "i2h_consts.svh"

module i2h_host
  import i2h_pkg::*;
#(
  parameter int P_PUP_CYC = `I2H_PUP_CYC  // power-up wait in clocks
) (
  input  wire logic     i_clk,
  input  wire logic     i_resetn,
  input  wire logic     i_req_valid,
  input  wire i2h_req_s i_req,
  output logic          o_req_ready,
  output logic          o_rsp_valid,
  output i2h_rsp_s      o_rsp,
  input  wire logic     i_scl_i,
  output logic          o_scl_o,
  output logic          o_scl_oe,
  input  wire logic     i_sda_i,
  output logic          o_sda_o,
  output logic          o_sda_oe
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [1:0]  sy1_r;                 // first sync stage, scl/sda
  logic [1:0]  sy2_r;                 // second sync stage
  logic        scl_s;                 // synchronised scl
  logic        sda_s;                 // synchronised sda
  logic [7:0]  qcnt_r;                // quarter-period counter
  logic        tick_w;                // end of a quarter period
  logic        bus_idle_w;            // both lines seen high
  logic [15:0] pup_r,  pup_nxt;       // power-up wait counter
  i2h_st_e     state_r, state_nxt;    // controller state
  logic [1:0]  ph_r,   ph_nxt;        // quarter phase of scl
  logic [3:0]  bit_r,  bit_nxt;       // bit slot in a byte
  logic [7:0]  sh_r,   sh_nxt;        // shift register
  i2h_op_e     op_r,   op_nxt;        // command under way
  logic        nack_r, nack_nxt;      // ninth bit to send on read
  logic        held_r, held_nxt;      // bus owned since a start or a failed recovery
  logic [3:0]  rcnt_r, rcnt_nxt;      // recovery clock count
  logic        scl_oe_r, scl_oe_nxt;  // pulling scl low
  logic        sda_oe_r, sda_oe_nxt;  // pulling sda low
  logic        rdy_r,  rdy_nxt;       // ready for a command
  logic        rsp_v_r, rsp_v_nxt;    // answer pulse
  i2h_rsp_s    rsp_r,  rsp_nxt;       // answer contents
  logic        pin_o_r;               // open-drain data level
  logic        take_w;                // command accepted now
  logic        needs_bus_w;           // command needs an owned bus
  logic [3:0]  pcnt_r;                // scl pulses in a byte (checks)

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  // both lines pass two flops; only the second stage is read
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          sy1_r[gi] <= 1'b1;
          sy2_r[gi] <= 1'b1;
        end else begin
          sy1_r[gi] <= (gi == 0) ? i_scl_i : i_sda_i;
          sy2_r[gi] <= sy1_r[gi];
        end
      end
    end
  endgenerate

  assign scl_s = sy2_r[0];
  assign sda_s = sy2_r[1];
  assign bus_idle_w  = scl_s & sda_s;
  assign tick_w      = (qcnt_r == 8'(`I2H_QTR_CYC - 1));
  assign take_w      = (state_r == ST_IDLE) && i_req_valid && rdy_r;
  assign needs_bus_w = (i_req.op == OP_WRITE) || (i_req.op == OP_READ) ||
                       (i_req.op == OP_STOP);

  // --------------------------------------------------------------
  // quarter-period divider
  // --------------------------------------------------------------
  // host makes scl
  always_ff @(posedge i_clk) begin
    if (!i_resetn || state_r == ST_IDLE) begin
      qcnt_r <= 8'h00;
    end else begin
      qcnt_r <= tick_w ? 8'h00 : qcnt_r + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    ph_nxt     = ph_r;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    op_nxt     = op_r;
    nack_nxt   = nack_r;
    held_nxt   = held_r;
    rcnt_nxt   = rcnt_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    rdy_nxt    = rdy_r;
    rsp_v_nxt  = 1'b0;
    rsp_nxt    = rsp_r;
    pup_nxt    = pup_r;
    case (state_r)
      ST_PUP: begin
        if (pup_r == 16'(P_PUP_CYC - 1)) begin
          state_nxt = ST_IDLE;
          rdy_nxt   = 1'b1;
        end else begin
          pup_nxt = pup_r + 16'h0001;
        end
      end
      ST_IDLE: begin
        if (take_w) begin
          op_nxt   = i_req.op;
          sh_nxt   = i_req.data;
          nack_nxt = i_req.nack;
          ph_nxt   = `I2H_PH_LOW;
          bit_nxt  = 4'h0;
          rcnt_nxt = 4'h0;
          if (needs_bus_w && !held_r) begin
            // refused: no start has opened the bus, answer at once
            rsp_v_nxt    = 1'b1;
            rsp_nxt.nack = 1'b1;
          end else begin
            rdy_nxt = 1'b0;
            case (i_req.op)
              OP_START:   state_nxt = ST_START;
              OP_STOP:    state_nxt = ST_STOP;
              OP_RECOVER: state_nxt = ST_RECOV;
              default:    state_nxt = ST_BIT;
            endcase
          end
        end
      end
      ST_START: begin
        if (tick_w) begin
          case (ph_r)
            `I2H_PH_LOW: begin
              sda_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_RISE;
            end
            `I2H_PH_RISE: begin
              scl_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_HIGH;
            end
            `I2H_PH_HIGH: begin
              if (bus_idle_w) begin
                sda_oe_nxt = 1'b1;
                ph_nxt     = `I2H_PH_FALL;
              end
            end
            default: begin
              scl_oe_nxt   = 1'b1;
              held_nxt     = 1'b1;
              state_nxt    = ST_IDLE;
              rdy_nxt      = 1'b1;
              rsp_v_nxt    = 1'b1;
              rsp_nxt.nack = 1'b0;
            end
          endcase
        end
      end
      ST_BIT: begin
        if (tick_w) begin
          case (ph_r)
            `I2H_PH_LOW: begin
              ph_nxt = `I2H_PH_RISE;
              if (bit_r == `I2H_BIT_END) begin
                sda_oe_nxt   = 1'b0;
                state_nxt    = ST_IDLE;
                rdy_nxt      = 1'b1;
                rsp_v_nxt    = 1'b1;
                rsp_nxt.data = sh_r;
              end else if (bit_r == `I2H_BIT_ACK) begin
                sda_oe_nxt = (op_r == OP_READ) && !nack_r;
              end else begin
                sda_oe_nxt = (op_r == OP_WRITE) && !sh_r[7];
              end
            end
            `I2H_PH_RISE: begin
              scl_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_HIGH;
            end
            `I2H_PH_HIGH: begin
              // sample mid-high, where data is settled
              ph_nxt = `I2H_PH_FALL;
              if (bit_r == `I2H_BIT_ACK) begin
                rsp_nxt.nack = sda_s;
              end else begin
                sh_nxt = {sh_r[6:0], sda_s};
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              ph_nxt     = `I2H_PH_LOW;
              bit_nxt    = bit_r + 4'h1;
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick_w) begin
          case (ph_r)
            `I2H_PH_LOW: begin
              sda_oe_nxt = 1'b1;
              ph_nxt     = `I2H_PH_RISE;
            end
            `I2H_PH_RISE: begin
              scl_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_HIGH;
            end
            `I2H_PH_HIGH: begin
              sda_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_FALL;
            end
            default: begin
              held_nxt     = 1'b0;
              state_nxt    = ST_IDLE;
              rdy_nxt      = 1'b1;
              rsp_v_nxt    = 1'b1;
              rsp_nxt.nack = 1'b0;
            end
          endcase
        end
      end
      ST_RECOV: begin
        if (tick_w) begin
          case (ph_r)
            `I2H_PH_LOW: begin
              sda_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_RISE;
            end
            `I2H_PH_RISE: begin
              scl_oe_nxt = 1'b0;
              ph_nxt     = `I2H_PH_HIGH;
            end
            `I2H_PH_HIGH: begin
              if (sda_s) begin
                // line freed: go straight to the start edge
                state_nxt = ST_START;
              end else begin
                rcnt_nxt = rcnt_r + 4'h1;
                ph_nxt   = `I2H_PH_FALL;
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              ph_nxt     = `I2H_PH_LOW;
              if (rcnt_r == `I2H_RECOV_MAX) begin
                // still stuck: only a power cycle helps now
                held_nxt     = 1'b1;
                state_nxt    = ST_IDLE;
                rdy_nxt      = 1'b1;
                rsp_v_nxt    = 1'b1;
                rsp_nxt.nack = 1'b1;
              end
            end
          endcase
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r  <= ST_PUP;
      pup_r    <= 16'h0000;
      ph_r     <= `I2H_PH_LOW;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      op_r     <= OP_START;
      nack_r   <= 1'b0;
      held_r   <= 1'b0;
      rcnt_r   <= 4'h0;
    end else begin
      state_r  <= state_nxt;
      pup_r    <= pup_nxt;
      ph_r     <= ph_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      op_r     <= op_nxt;
      nack_r   <= nack_nxt;
      held_r   <= held_nxt;
      rcnt_r   <= rcnt_nxt;
    end
  end

  // output flops; the data level stays low, the enable does the work
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rdy_r    <= 1'b0;
      rsp_v_r  <= 1'b0;
      rsp_r    <= '0;
      pin_o_r  <= 1'b0;
    end else begin
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      rdy_r    <= rdy_nxt;
      rsp_v_r  <= rsp_v_nxt;
      rsp_r    <= rsp_nxt;
      pin_o_r  <= 1'b0;
    end
  end

  assign o_req_ready = rdy_r;
  assign o_rsp_valid = rsp_v_r;
  assign o_rsp       = rsp_r;
  assign o_scl_o     = pin_o_r;
  assign o_scl_oe    = scl_oe_r;
  assign o_sda_o     = pin_o_r;
  assign o_sda_oe    = sda_oe_r;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  // scl pulses released within one byte slot
  always_ff @(posedge i_clk) begin
    if (!i_resetn || state_r != ST_BIT) begin
      pcnt_r <= 4'h0;
    end else if (scl_oe_r && !scl_oe_nxt) begin
      pcnt_r <= pcnt_r + 4'h1;
    end
  end

  property p_pup_wait;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_PUP) |-> !rdy_r && !scl_oe_r && !sda_oe_r;
  endproperty
  a_pup_wait: assert property (p_pup_wait) else $error("command window open too early");

  property p_pup_len;
    @(posedge i_clk) disable iff (!i_resetn)
    ($rose(rdy_r) && $past(state_r) == ST_PUP) |-> $past(pup_r) == 16'(P_PUP_CYC - 1);
  endproperty
  a_pup_len: assert property (p_pup_len) else $error("power-up wait has wrong length");

  property p_nine_clk;
    @(posedge i_clk) disable iff (!i_resetn)
    (rsp_v_r && $past(state_r) == ST_BIT) |-> $past(pcnt_r) == 4'h9;
  endproperty
  a_nine_clk: assert property (p_nine_clk) else $error("byte slot not nine clocks");

  property p_sda_stable;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_BIT && $past(state_r) == ST_BIT && !scl_oe_r && !$past(scl_oe_r))
      |-> sda_oe_r == $past(sda_oe_r);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("data moved while scl high");

  property p_tx_release;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_BIT && op_r == OP_WRITE && bit_r == `I2H_BIT_ACK &&
     ph_r != `I2H_PH_LOW) |-> !sda_oe_r;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("data held in ack slot");

  property p_rx_release;
    @(posedge i_clk) disable iff (!i_resetn)
    (rsp_v_r && $past(state_r) == ST_BIT) |-> !sda_oe_r && scl_oe_r;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("data not released after ack");

  property p_start_edge;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_START && ph_r == `I2H_PH_HIGH && tick_w && bus_idle_w)
      |=> sda_oe_r && !scl_oe_r ##1 sda_oe_r;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start edge malformed");

  property p_idle_wait;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_START && ph_r == `I2H_PH_HIGH && tick_w && !bus_idle_w) |=> !sda_oe_r;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("start on a busy bus");

  property p_stop_edge;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_STOP && ph_r == `I2H_PH_HIGH && tick_w) |=> !sda_oe_r && !scl_oe_r;
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("stop edge malformed");

  property p_recov_max;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_RECOV) |-> rcnt_r <= `I2H_RECOV_MAX;
  endproperty
  a_recov_max: assert property (p_recov_max) else $error("too many dummy clocks");

  property p_msb_in;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == ST_BIT && ph_r == `I2H_PH_HIGH && tick_w && bit_r < `I2H_BIT_ACK)
      |=> sh_r[0] == $past(sda_s) && sh_r[7:1] == $past(sh_r[6:0]);
  endproperty
  a_msb_in: assert property (p_msb_in) else $error("shift order wrong");

  property p_open_drain;
    @(posedge i_clk) disable iff (!i_resetn)
    !o_sda_o && !o_scl_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_need_start;
    @(posedge i_clk) disable iff (!i_resetn)
    (take_w && needs_bus_w && !held_r) |=> rsp_v_r && rsp_r.nack && state_r == ST_IDLE;
  endproperty
  a_need_start: assert property (p_need_start) else $error("transfer without start");

endmodule // i2h_host

/* File: rtl/i2h_pkg.sv */
package i2h_pkg;
  // --------------------------------------------------------------
  // user commands
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ,
    OP_RECOVER
  } i2h_op_e;

  // controller states
  typedef enum logic [2:0] {
    ST_PUP,
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP,
    ST_RECOV
  } i2h_st_e;

  // one command from the user side
  typedef struct packed {
    i2h_op_e    op;    // what to do on the bus
    logic [7:0] data;  // byte to send for a write
    logic       nack;  // for a read: answer 1 (end) instead of 0
  } i2h_req_s;

  // one answer to the user side
  typedef struct packed {
    logic [7:0] data;  // byte shifted in from the bus
    logic       nack;  // ninth-bit level seen, or refusal / failure
  } i2h_rsp_s;
endpackage

/* File: verif/i2h_dev_model.sv */
// --------------------------------------------------------------
// behavioural client device on the two-wire bus
// --------------------------------------------------------------
module i2h_dev_model #(
  parameter int P_HANG = 3  // falling clocks before a hung line lets go
) (
  input  wire logic       i_scl,     // clock line level
  input  wire logic       i_sda,     // data line level
  input  wire logic       i_por_n,   // low holds the device in power-on reset
  input  wire logic       i_rd,      // device sends bytes instead of taking them
  input  wire logic       i_nak,     // refuse bytes that come in
  input  wire logic       i_stuck,   // rising edge hangs the data line
  input  wire logic [7:0] i_tx,      // byte to send
  output logic            o_sda_oe,  // high pulls data low
  output logic      [7:0] o_rx,      // last byte taken in
  output logic            o_hack,    // ninth bit returned by the host on a read
  output int              o_starts,  // start conditions seen
  output int              o_stops,   // stop conditions seen
  output int              o_errs     // framing faults seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       active = 1'b0;  // between a start and a stop
  int         bitn   = 0;     // rising clocks seen in this byte slot
  int         hold   = 0;     // falls left while the line is hung
  logic [7:0] sh     = 8'h00; // incoming shift register

  // quiet at time zero
  initial begin
    o_sda_oe = 1'b0;
    o_rx     = 8'h00;
    o_hack   = 1'b0;
    o_starts = 0;
    o_stops  = 0;
    o_errs   = 0;
  end

  // start seen only out of reset, on the data edge
  always @(negedge i_sda) begin
    // own hang pulls data while clock is high, so it is no start
    if (i_scl === 1'b1 && i_por_n === 1'b1 && hold == 0) begin
      // no start inside a byte slot; the clock rise that sets up
      // a repeated start opens a slot but carries no bit yet
      if (active && bitn > 1) o_errs++;
      active = 1'b1;
      bitn   = 0;
      o_starts++;
    end
  end

  always @(posedge i_sda) begin
    if (i_scl === 1'b1 && i_por_n === 1'b1 && active) begin
      if (bitn > 1) o_errs++;  // the set-up rise of a stop carries no bit
      active = 1'b0;
      o_stops++;
    end
  end

  // sample on the rising clock, any number of bytes
  always @(posedge i_scl) begin
    if (active && hold == 0) begin
      if (bitn < 8) sh = {sh[6:0], i_sda};
      else o_hack = i_sda;
      bitn++;
    end
  end

  // change on the falling clock, pull low only
  always @(negedge i_scl) begin
    if (hold > 0) begin
      // let go after a few dummy clocks
      hold--;
      o_sda_oe = (hold != 0);
    end else if (active) begin
      if (bitn == 8) o_sda_oe = !i_rd && !i_nak;  // acknowledge or release
      else if (bitn == 9) begin
        bitn = 0;
        if (!i_rd) o_rx = sh;
        o_sda_oe = i_rd && !o_hack && !i_tx[7];    // next byte only if acked
      end else if (i_rd) o_sda_oe = !i_tx[7 - bitn];
      else o_sda_oe = 1'b0;
    end
  end

  always @(posedge i_stuck) begin
    hold     = P_HANG;
    o_sda_oe = 1'b1;
  end
endmodule // i2h_dev_model

/* File: verif/tb_i2h_host.sv */
module tb_i2h_host
  import i2h_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam int PUP = 20;  // shortened power-up wait

  logic       i_clk;
  logic       i_resetn;
  logic       req_valid;
  i2h_req_s   req;
  logic       req_ready;
  logic       rsp_valid;
  i2h_rsp_s   rsp;
  logic       scl_oe;
  logic       sda_oe;
  logic       dev_oe;
  logic       scl_o;      // host clock pin level, must stay low
  logic       sda_o;      // host data pin level, must stay low
  logic       scl;        // resolved wire, pulled up
  logic       sda;        // resolved wire, pulled up
  logic       por_n;
  logic       rd;
  logic       nak;
  logic       stuck;
  logic [7:0] tx;
  logic [7:0] rx;
  logic       hack;
  int         starts;
  int         stops;
  int         errs;
  int         error_cnt   = 0;
  int         check_count = 0;

  // open drain: any pull wins, else the pull-up
  assign scl = !scl_oe;
  assign sda = !(sda_oe || dev_oe);

  i2h_host #(.P_PUP_CYC(PUP)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .i_scl_i(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
    .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe));

  i2h_dev_model dev_u (
    .i_scl(scl), .i_sda(sda), .i_por_n(por_n), .i_rd(rd), .i_nak(nak),
    .i_stuck(stuck), .i_tx(tx), .o_sda_oe(dev_oe), .o_rx(rx), .o_hack(hack),
    .o_starts(starts), .o_stops(stops), .o_errs(errs));

  // --------------------------------------------------------------
  // clock, verdict, watchdog
  // --------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // whole run is near 0.5 ms of bus time; give up at 0.8 ms (80k clocks)
  initial begin
    #800000;
    error_cnt++;
    finish_test();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // offer one command, wait bounded for its answer
  task automatic do_op(input i2h_op_e op, input logic [7:0] d, input logic nk,
                       output i2h_rsp_s r);
    int n;
    n = 0;
    @(posedge i_clk);
    while (req_ready !== 1'b1) @(posedge i_clk);
    req_valid <= 1'b1;
    req       <= '{op: op, data: d, nack: nk};
    @(posedge i_clk);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    r = rsp;
    if (n >= 20000) error_cnt++;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    check({req_ready, rsp_valid, scl_oe, sda_oe}, 4'h0);
    check({scl_o, sda_o}, 2'h0);
    while (req_ready !== 1'b1 && n < 1000) begin
      @(posedge i_clk);
      n++;
    end
    check(n >= PUP && n <= PUP + 4, 1'b1);
    check({scl, sda}, 2'h3);
  endtask

  task automatic t_refuse();
    i2h_rsp_s r;
    do_op(OP_WRITE, 8'h3A, 1'b0, r);
    check(r.nack, 1'b1);
    check(32'(starts), 32'h0);
    check({scl, sda}, 2'h3);
  endtask

  task automatic t_write();
    i2h_rsp_s r;
    do_op(OP_START, 8'h00, 1'b0, r);
    check(32'(starts), 32'h1);
    do_op(OP_WRITE, 8'h3A, 1'b0, r);
    check(rx, 8'h3A);
    check(r, {8'h3A, 1'b0});
    nak <= 1'b1;
    do_op(OP_WRITE, 8'h61, 1'b0, r);
    check(r, {8'h61, 1'b1});
    check(rx, 8'h61);
    nak <= 1'b0;
  endtask

  task automatic t_read();
    i2h_rsp_s r;
    rd <= 1'b1;
    do_op(OP_START, 8'h00, 1'b0, r);
    check(32'(starts), 32'h2);
    do_op(OP_READ, 8'h00, 1'b0, r);
    check(r, {8'hB4, 1'b0});
    check(hack, 1'b0);
    do_op(OP_READ, 8'h00, 1'b1, r);
    check(r, {8'hB4, 1'b1});
    check({hack, sda}, 2'h3);
    rd <= 1'b0;
    do_op(OP_STOP, 8'h00, 1'b0, r);
    check(32'(stops), 32'h1);
    check({scl, sda}, 2'h3);
  endtask

  task automatic t_por();
    i2h_rsp_s r;
    por_n <= 1'b0;
    do_op(OP_START, 8'h00, 1'b0, r);
    do_op(OP_STOP, 8'h00, 1'b0, r);
    check(32'(starts), 32'h2);
    check(32'(stops), 32'h1);
    por_n <= 1'b1;
  endtask

  task automatic t_recover();
    i2h_rsp_s r;
    stuck <= 1'b1;
    @(posedge i_clk);
    check(sda, 1'b0);
    do_op(OP_RECOVER, 8'h00, 1'b0, r);
    check(r.nack, 1'b0);
    check(32'(starts), 32'h3);
    stuck <= 1'b0;
    do_op(OP_STOP, 8'h00, 1'b0, r);
    check(32'(stops), 32'h2);
    check({scl, sda}, 2'h3);
    check(32'(errs), 32'h0);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    req_valid = 1'b0;
    req       = '0;
    i_resetn  = 1'b0;
    por_n     = 1'b1;
    rd        = 1'b0;
    nak       = 1'b0;
    stuck     = 1'b0;
    tx        = 8'hB4;  // not a palindrome, so bit order shows
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_refuse();
    t_write();
    t_read();
    t_por();
    t_recover();
    finish_test();
  end
endmodule // tb_i2h_host
